// ===== include/ssr_consts.vh
// constants for the state save/restore engine
// assumes: included by bare name from the design files under hw/
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH

// axi4-lite register byte offsets
`define SSR_A_CTRL   8'h00
`define SSR_A_STAT   8'h04
`define SSR_A_IMLO   8'h08
`define SSR_A_IMHI   8'h0C
`define SSR_A_FEM    8'h10
`define SSR_A_BASE   8'h14
`define SSR_A_WIDX   8'h18
`define SSR_A_WDAT   8'h1C
`define SSR_A_FPCW   8'h20
`define SSR_A_MXCS   8'h24
`define SSR_A_BMAP   8'h28

// control and status bit positions
`define SSR_C_START  0
`define SSR_C_OP     1
`define SSR_C_M64    2
`define SSR_S_BUSY   0
`define SSR_S_DONE   1
`define SSR_RESP_OK  2'b00
`define SSR_RESP_ERR 2'b10

// component bits, same order as the feature-enable mask
`define SSR_C_X87    0
`define SSR_C_MV     1
`define SSR_C_UH     2
`define SSR_FEM_RST  3'h1
`define SSR_FEM_BAD  2'b10

// hardware initial values and the media control mask written by save
`define SSR_FCW_INIT 16'h037F
`define SSR_FSW_INIT 16'h0000
`define SSR_FTW_INIT 8'h00
`define SSR_MXMASK   32'h0000FFFF

// field ranges inside a 16-byte slot
`define SSR_F_FCW    15:0
`define SSR_F_FSW    31:16
`define SSR_F_FTW    39:32
`define SSR_F_FOP    63:48
`define SSR_F_LO     63:0
`define SSR_F_HI     127:64
`define SSR_F_MX     95:64
`define SSR_F_ST     79:0
`define SSR_F_ESB    23
`define SSR_FSW_ES   7

// slot and step numbering (one step per 16-byte slot)
`define SSR_HDR_SLOT 6'h20
`define SSR_HI_SLOT  6'h24
`define SSR_STEP_X87 6'h00
`define SSR_STEP_PTR 6'h01
`define SSR_STEP_ST  6'h02
`define SSR_STEP_XMM 6'h0A
`define SSR_XMM_LO_END 6'h12
`define SSR_STEP_HI  6'h1A
`define SSR_HI_LO_END 6'h22
`define SSR_STEPS    6'h2A
`define SSR_MV_BASE  8
`define SSR_UH_BASE  24
`define SSR_NMV      16
`define SSR_NLO      8
`define SSR_VIDX_FIP 6'h28
`define SSR_VIDX_FDP 6'h29
`define SSR_NVEC     42
`define SSR_STRB_NONE 16'h0000
`define SSR_STRB_ST  16'h03FF
`define SSR_STRB_ALL 16'hFFFF
`define SSR_STRB_HDR 16'h00FF

`endif

// ===== hw/ssr_slot_map.v
// slot map: step number to slot address, state index and byte strobes
// assumes: purely combinational, driven by the engine on the same clock
`timescale 1ns/1ns
`include "ssr_consts.vh"

module ssr_slot_map (
    input  wire [5:0]  step,
    input  wire        mode64,
    input  wire        fault,
    input  wire [2:0]  ld,
    input  wire        mx,
    output reg  [5:0]  slot,
    output reg  [5:0]  vidx,
    output reg  [15:0] strb
);

// strobes are empty for anything that must not touch memory
always @* begin
    slot = step;
    vidx = step - `SSR_STEP_ST;
    strb = `SSR_STRB_NONE;
    if (step == `SSR_STEP_X87) begin
        // pointer bytes only with a pending fault
        strb = {{8{ld[`SSR_C_X87] & fault}}, {8{ld[`SSR_C_X87]}}};
    end else if (step == `SSR_STEP_PTR) begin
        // media control moves with either vector component
        strb = {{8{mx}}, {8{ld[`SSR_C_X87] & fault}}};
    end else if (step < `SSR_STEP_XMM) begin
        if (ld[`SSR_C_X87]) begin
            strb = `SSR_STRB_ST;
        end
    end else if (step < `SSR_STEP_HI) begin
        if (ld[`SSR_C_MV] && (mode64 || step < `SSR_XMM_LO_END)) begin
            strb = `SSR_STRB_ALL;
        end
    end else begin
        slot = step - `SSR_STEP_HI + `SSR_HI_SLOT;
        if (ld[`SSR_C_UH] && (mode64 || step < `SSR_HI_LO_END)) begin
            strb = `SSR_STRB_ALL;
        end
    end
end

endmodule // ssr_slot_map

// ===== hw/ssr_engine.v
// state save/restore engine with axi4-lite control and a slot memory port
// assumes: memory answers mem_req with a one-cycle mem_ack on aclk
//
// Functional notes
// - header lives at byte 512 of area
// - first header quadword is the bitmap
// - bitmap bits follow feature-enable mask order
// - save sets bitmap bit of each selected component
// - save alters only selected bitmap bits
// - restore only components in both masks
// - bitmap set: load component from memory
// - bitmap clear: load hardware initial values
// - x87 init 037F, 0000, empty tags
// - x87 init zeroes pointers and stack
// - media init zeroes 16 or 8 regs
// - upper-half init zeroes 16 or 8
// - media control always read with vectors
// - pointers moved only with pending fault
// - media regs 8-15 skipped outside 64-bit
// - upper halves 8-15 skipped outside 64-bit
// - operate on mask AND; privileged mask writes
`timescale 1ns/1ns
`include "ssr_consts.vh"

module ssr_engine (
    input  wire          aclk,
    input  wire          aresetn,
    input  wire [7:0]    s_axi_awaddr,
    input  wire [2:0]    s_axi_awprot,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    input  wire [7:0]    s_axi_araddr,
    input  wire [2:0]    s_axi_arprot,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    output reg           mem_req,
    output reg           mem_we,
    output reg  [31:0]   mem_addr,
    output reg  [127:0]  mem_wdata,
    output reg  [15:0]   mem_strb,
    input  wire [127:0]  mem_rdata,
    input  wire          mem_ack
);

localparam S_IDLE = 5'b00001;
localparam S_HRD  = 5'b00010;
localparam S_STEP = 5'b00100;
localparam S_MEM  = 5'b01000;
localparam S_HWR  = 5'b10000;

////////////////////////////////////////////////////////////////////////
// software-visible registers and processor state
reg  [7:0]   waddr_q;
reg          wpriv_q;
reg  [31:0]  wdata_q;
reg  [3:0]   wstrb_q;
reg          op_q;
reg          m64_q;
reg          start_q;
reg          done_q;
reg  [31:0]  imlo_q;
reg  [31:0]  imhi_q;
reg  [2:0]   fem_q;
reg  [31:0]  base_q;
reg  [7:0]   widx_q;
reg  [15:0]  fcw_q;
reg  [15:0]  fsw_q;
reg  [7:0]   ftw_q;
reg  [15:0]  fop_q;
reg  [31:0]  media_control_status_q;
reg  [127:0] vec_q [0:`SSR_NVEC-1];
reg  [4:0]   st_q;
reg  [5:0]   step_q;
reg          eop_q;
reg  [2:0]   sel_q;
reg  [63:0]  bv_q;
reg          flt_q;
integer      i;

wire [5:0]   sm_slot;
wire [5:0]   sm_vidx;
wire [15:0]  sm_strb;
reg  [127:0] wdat;
reg  [31:0]  rd_d;
reg          rmap;

wire [31:0] wm = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
wire [31:0] wd = wdata_q & wm;
wire do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
wire idle = st_q == S_IDLE;
wire save = ~eop_q;
wire [5:0] widx = widx_q[7:2];
wire [6:0] wsel = {widx_q[1:0], 5'h00};
wire wvok = widx < `SSR_NVEC;
wire fem_ok = wpriv_q && wd[2:1] != `SSR_FEM_BAD;
wire w_ctl = do_wr & (waddr_q == `SSR_A_CTRL);
wire w_st = do_wr & (waddr_q == `SSR_A_STAT);
wire w_win = do_wr & (waddr_q == `SSR_A_WDAT);
wire w_fp = do_wr & (waddr_q == `SSR_A_FPCW);
wire w_mx = do_wr & (waddr_q == `SSR_A_MXCS);
wire wmap = waddr_q <= `SSR_A_MXCS && waddr_q[1:0] == 2'b00;
wire [2:0] ld = save ? sel_q : sel_q & bv_q[2:0];
wire fault = save ? fsw_q[`SSR_FSW_ES] : (step_q == `SSR_STEP_X87) | flt_q;
wire ack_hrd = (st_q == S_HRD) & mem_ack;
wire ack_mem = (st_q == S_MEM) & mem_ack;
wire fin = (st_q == S_HWR & mem_ack) | (st_q == S_STEP & step_q == `SSR_STEPS & eop_q);
wire [2:0] initc = sel_q & ~mem_rdata[2:0];

// byte-lane merge for a partial axi write
function [31:0] mrg;
    input [31:0] old;
    begin
        mrg = (old & ~wm) | wd;
    end
endfunction

ssr_slot_map u_map (
    .step   (step_q),
    .mode64 (m64_q),
    .fault  (fault),
    .ld     (ld),
    .mx     (sel_q[`SSR_C_MV] | sel_q[`SSR_C_UH]),
    .slot   (sm_slot),
    .vidx   (sm_vidx),
    .strb   (sm_strb)
);

////////////////////////////////////////////////////////////////////////
// axi4-lite write channel: aw and w taken in either order
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `SSR_RESP_OK;
        waddr_q       <= 8'h00;
        wpriv_q       <= 1'b0;
        wdata_q       <= 32'h00000000;
        wstrb_q       <= 4'h0;
    end else begin
        if (s_axi_awvalid & s_axi_awready) begin
            s_axi_awready <= 1'b0;
            waddr_q       <= s_axi_awaddr;
            wpriv_q       <= s_axi_awprot[0];
        end
        if (s_axi_wvalid & s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
        end
        if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            // refused mask writes answer with an error
            if (!wmap || (waddr_q == `SSR_A_FEM && !fem_ok)) begin
                s_axi_bresp <= `SSR_RESP_ERR;
            end else begin
                s_axi_bresp <= `SSR_RESP_OK;
            end
        end
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

// control registers written by software
always @(posedge aclk) begin
    if (!aresetn) begin
        op_q    <= 1'b0;
        m64_q   <= 1'b0;
        start_q <= 1'b0;
        done_q  <= 1'b0;
        imlo_q  <= 32'h00000000;
        imhi_q  <= 32'h00000000;
        fem_q   <= `SSR_FEM_RST;
        base_q  <= 32'h00000000;
        widx_q  <= 8'h00;
    end else begin
        start_q <= w_ctl & wstrb_q[0] & wdata_q[`SSR_C_START] & idle;
        // completion set wins over a same-cycle clear
        done_q  <= fin | (done_q & ~(w_st & wd[`SSR_S_DONE]));
        if (w_ctl && wstrb_q[0]) begin
            op_q  <= wdata_q[`SSR_C_OP];
            m64_q <= wdata_q[`SSR_C_M64];
        end
        if (do_wr) begin
            case (waddr_q)
                `SSR_A_IMLO: imlo_q <= mrg(imlo_q);
                `SSR_A_IMHI: imhi_q <= mrg(imhi_q);
                `SSR_A_BASE: base_q <= mrg(base_q);
                `SSR_A_WIDX: widx_q <= (widx_q & ~wm[7:0]) | wd[7:0];
                `SSR_A_FEM: begin
                    // only privileged, legal writes land; x87 bit stays set
                    if (fem_ok && wstrb_q[0]) begin
                        fem_q <= wdata_q[2:0] | `SSR_FEM_RST;
                    end
                end
                default: ;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// axi4-lite read channel: one read at a time, answer one cycle later
always @* begin
    rmap = 1'b1;
    rd_d = 32'h00000000;
    case (s_axi_araddr)
        `SSR_A_CTRL: rd_d = {29'h0, m64_q, op_q, 1'b0};
        `SSR_A_STAT: rd_d = {30'h0, done_q, ~idle};
        `SSR_A_IMLO: rd_d = imlo_q;
        `SSR_A_IMHI: rd_d = imhi_q;
        `SSR_A_FEM:  rd_d = {29'h0, fem_q};
        `SSR_A_BASE: rd_d = base_q;
        `SSR_A_WIDX: rd_d = {24'h0, widx_q};
        `SSR_A_WDAT: rd_d = wvok ? vec_q[widx][wsel +: 32] : 32'h00000000;
        `SSR_A_FPCW: rd_d = {fsw_q, fcw_q};
        `SSR_A_MXCS: rd_d = media_control_status_q;
        `SSR_A_BMAP: rd_d = bv_q[31:0];
        default:     rmap = 1'b0;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `SSR_RESP_OK;
    end else begin
        if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_d;
            s_axi_rresp   <= rmap ? `SSR_RESP_OK : `SSR_RESP_ERR;
        end
        if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// save data for the current slot, legacy image layout
always @* begin
    case (step_q)
        `SSR_STEP_X87: wdat = {vec_q[`SSR_VIDX_FIP][`SSR_F_LO], fop_q, 8'h00, ftw_q, fsw_q, fcw_q};
        `SSR_STEP_PTR: wdat = {`SSR_MXMASK, media_control_status_q, vec_q[`SSR_VIDX_FDP][`SSR_F_LO]};
        default:       wdat = vec_q[sm_vidx];
    endcase
end

// sequencer: header read, one slot per step, header write on save
always @(posedge aclk) begin
    if (!aresetn) begin
        st_q      <= S_IDLE;
        step_q    <= `SSR_STEP_X87;
        eop_q     <= 1'b0;
        sel_q     <= 3'h0;
        bv_q      <= 64'h0;
        mem_req   <= 1'b0;
        mem_we    <= 1'b0;
        mem_addr  <= 32'h00000000;
        mem_wdata <= 128'h0;
        mem_strb  <= `SSR_STRB_NONE;
    end else begin
        case (st_q)
            S_IDLE: begin
                if (start_q) begin
                    eop_q    <= op_q;
                    sel_q    <= imlo_q[2:0] & fem_q;
                    mem_req  <= 1'b1;
                    mem_we   <= 1'b0;
                    mem_addr <= base_q + {22'h0, `SSR_HDR_SLOT, 4'h0};
                    mem_strb <= `SSR_STRB_HDR;
                    st_q     <= S_HRD;
                end
            end
            S_HRD: begin
                if (mem_ack) begin
                    mem_req <= 1'b0;
                    bv_q    <= mem_rdata[`SSR_F_LO];
                    step_q  <= `SSR_STEP_X87;
                    st_q    <= S_STEP;
                end
            end
            S_STEP: begin
                if (step_q == `SSR_STEPS) begin
                    if (save) begin
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= base_q + {22'h0, `SSR_HDR_SLOT, 4'h0};
                        // unselected bitmap bits written back as read
                        mem_wdata <= {64'h0, bv_q | {61'h0, sel_q}};
                        mem_strb  <= `SSR_STRB_HDR;
                        st_q      <= S_HWR;
                    end else begin
                        st_q <= S_IDLE;
                    end
                end else if (|sm_strb) begin
                    mem_req   <= 1'b1;
                    mem_we    <= save;
                    mem_addr  <= base_q + {22'h0, sm_slot, 4'h0};
                    mem_wdata <= wdat;
                    mem_strb  <= sm_strb;
                    st_q      <= S_MEM;
                end else begin
                    // nothing to move here: skip in one cycle
                    step_q <= step_q + 6'h01;
                end
            end
            S_MEM: begin
                if (mem_ack) begin
                    mem_req <= 1'b0;
                    step_q  <= step_q + 6'h01;
                    st_q    <= S_STEP;
                end
            end
            S_HWR: begin
                if (mem_ack) begin
                    mem_req <= 1'b0;
                    bv_q    <= bv_q | {61'h0, sel_q};
                    st_q    <= S_IDLE;
                end
            end
            default: st_q <= S_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// processor state: window writes, restore loads and initial values
always @(posedge aclk) begin
    if (!aresetn) begin
        fcw_q   <= `SSR_FCW_INIT;
        fsw_q   <= `SSR_FSW_INIT;
        ftw_q   <= `SSR_FTW_INIT;
        fop_q   <= 16'h0000;
        media_control_status_q <= 32'h00000000;
        flt_q   <= 1'b0;
        for (i = 0; i < `SSR_NVEC; i = i + 1) begin
            vec_q[i] <= 128'h0;
        end
    end else begin
        // software access loses to a running restore
        if (w_win && wvok) begin
            vec_q[widx][wsel +: 32] <= mrg(vec_q[widx][wsel +: 32]);
        end
        if (w_fp) begin
            {fsw_q, fcw_q} <= mrg({fsw_q, fcw_q});
        end
        if (w_mx) begin
            media_control_status_q <= mrg(media_control_status_q);
        end
        // after the header read, initialise components whose bit is clear
        if (ack_hrd && eop_q) begin
            flt_q <= 1'b0;
            if (initc[`SSR_C_X87]) begin
                fcw_q <= `SSR_FCW_INIT;
                fsw_q <= `SSR_FSW_INIT;
                ftw_q <= `SSR_FTW_INIT;
                vec_q[`SSR_VIDX_FIP] <= 128'h0;
                vec_q[`SSR_VIDX_FDP] <= 128'h0;
                for (i = 0; i < `SSR_NLO; i = i + 1) begin
                    vec_q[i] <= 128'h0;
                end
            end
            for (i = 0; i < `SSR_NMV; i = i + 1) begin
                if (m64_q || i < `SSR_NLO) begin
                    if (initc[`SSR_C_MV]) begin
                        vec_q[`SSR_MV_BASE + i] <= 128'h0;
                    end
                    if (initc[`SSR_C_UH]) begin
                        vec_q[`SSR_UH_BASE + i] <= 128'h0;
                    end
                end
            end
        end
        // restore load of one slot, only the bytes that were wanted
        if (ack_mem && eop_q) begin
            if (step_q == `SSR_STEP_X87) begin
                fcw_q <= mem_rdata[`SSR_F_FCW];
                fsw_q <= mem_rdata[`SSR_F_FSW];
                ftw_q <= mem_rdata[`SSR_F_FTW];
                fop_q <= mem_rdata[`SSR_F_FOP];
                // fault decided by the state being loaded
                flt_q <= mem_rdata[`SSR_F_ESB];
                if (mem_rdata[`SSR_F_ESB]) begin
                    vec_q[`SSR_VIDX_FIP] <= {64'h0, mem_rdata[`SSR_F_HI]};
                end
            end else if (step_q == `SSR_STEP_PTR) begin
                if (sm_strb[0]) begin
                    vec_q[`SSR_VIDX_FDP] <= {64'h0, mem_rdata[`SSR_F_LO]};
                end
                if (sm_strb[15]) begin
                    media_control_status_q <= mem_rdata[`SSR_F_MX];
                end
            end else if (sm_strb[15]) begin
                vec_q[sm_vidx] <= mem_rdata;
            end else begin
                vec_q[sm_vidx] <= {48'h0, mem_rdata[`SSR_F_ST]};
            end
        end
    end
end

endmodule // ssr_engine

// ===== dv/ssr_engine_properties.sv
// port checker for the save/restore engine
// assumes: bound to ssr_engine, one clock, sync active-low reset
`timescale 1ns/1ns
`include "ssr_consts.vh"

module ssr_engine_properties (
    input logic         aclk,
    input logic         aresetn,
    input logic         s_axi_awvalid,
    input logic         s_axi_awready,
    input logic         s_axi_wvalid,
    input logic         s_axi_wready,
    input logic [1:0]   s_axi_bresp,
    input logic         s_axi_bvalid,
    input logic         s_axi_bready,
    input logic         s_axi_arvalid,
    input logic         s_axi_arready,
    input logic [31:0]  s_axi_rdata,
    input logic         s_axi_rvalid,
    input logic         s_axi_rready,
    input logic         mem_req,
    input logic         mem_we,
    input logic [31:0]  mem_addr,
    input logic [127:0] mem_wdata,
    input logic [15:0]  mem_strb,
    input logic         mem_ack
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////
    // register bus timing
    a_b_two_late: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer not two cycles after take");
    a_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not next cycle");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_ready_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken before answer");

    ////////////////////////////////////////////////////////////////
    // slot accesses: one whole aligned slot, held until acknowledged
    a_slot_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
        && $stable(mem_strb) && $stable(mem_wdata))
        else $error("slot request changed before ack");
    a_slot_align: assert property (mem_req |-> mem_addr[3:0] == 4'h0)
        else $error("slot address not 16-byte aligned");
    a_ack_release: assert property (mem_ack |=> !mem_req)
        else $error("request not released after ack");
    a_write_lanes: assert property (mem_req && mem_we |-> mem_strb != `SSR_STRB_NONE)
        else $error("slot write with no lanes");

    c_save_slot: cover property (mem_req && mem_we && mem_ack);
    c_load_slot: cover property (mem_req && !mem_we && mem_ack);
    c_refused: cover property (s_axi_bvalid && s_axi_bresp == `SSR_RESP_ERR);
endmodule // ssr_engine_properties

bind ssr_engine ssr_engine_properties u_ssr_engine_properties (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_strb, .mem_ack);

// ===== dv/ssr_mem_model.sv
// save-area memory: 16-byte slots keyed by address/16
// assumes: engine holds mem_req until the cycle after mem_ack
`timescale 1ns/1ns

module ssr_mem_model (
    input  logic         aclk,
    input  logic         aresetn,
    input  logic         slow,
    input  logic         mem_req,
    input  logic         mem_we,
    input  logic [31:0]  mem_addr,
    input  logic [127:0] mem_wdata,
    input  logic [15:0]  mem_strb,
    output logic [127:0] mem_rdata,
    output logic         mem_ack
);
    logic [127:0] mem [int];
    logic [127:0] line;
    int           key;
    int           wait_q;
    logic         served_q;

    ////////////////////////////////////////////////////////////////
    // one ack per request; slow mode stalls three extra cycles
    always @(posedge aclk) begin
        key = int'(mem_addr[31:4]);
        line = mem.exists(key) ? mem[key] : 128'h0;
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata; // released data never keeps its value
        if (!aresetn || !mem_req) begin
            wait_q <= 0;
            served_q <= 1'b0;
            if (!aresetn) mem_rdata <= 128'h0;
        end else if (!served_q && wait_q < (slow ? 3 : 0)) begin
            wait_q <= wait_q + 1;
        end else if (!served_q) begin
            served_q <= 1'b1;
            mem_ack <= 1'b1;
            mem_rdata <= line;
            // merge only enabled lanes, others keep what software left
            for (int b = 0; b < 16; b++) if (mem_we && mem_strb[b]) line[8*b +: 8] = mem_wdata[8*b +: 8];
            if (mem_we) mem[key] = line;
        end
    end
endmodule // ssr_mem_model

// ===== dv/ssr_engine_test.sv
// bench for the save/restore engine: axi4-lite tasks, memory backdoor
// assumes: save area at 1000h, memory model on the slot port
`timescale 1ns/1ns
`include "ssr_consts.vh"

module ssr_engine_test;
    localparam int  KB  = 'h100; // slot key of the area base
    localparam logic [127:0] PAT = 128'h5A5A_0000_0000_0000_0000_0000_0000_5A5A;
    logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0]   s_axi_awprot = 3'h1, s_axi_arprot = 3'h0;
    logic [31:0]  s_axi_wdata = 32'h0;
    logic [3:0]   s_axi_wstrb = 4'hF;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_req, mem_we, mem_ack;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic [31:0]  s_axi_rdata, mem_addr;
    logic [127:0] mem_wdata, mem_rdata;
    logic [15:0]  mem_strb;
    int n_fail = 0, checks = 0, cyc = 0;

    ssr_engine    u_ssr_engine (.*);
    ssr_mem_model u_ssr_mem_model (.*);

    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial forever #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // bus tasks: valid held until its own ready edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p = 3'h1,
                      input logic [1:0] er = `SSR_RESP_OK);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awprot <= p;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = `SSR_RESP_OK);
        rd(a);
        chk(s_axi_rdata, exp);
        chk(s_axi_rresp, er);
    endtask

    // start an operation, poll done, clear it
    task automatic run(input logic [31:0] ctrl);
        wr(`SSR_A_CTRL, ctrl);
        do rd(`SSR_A_STAT); while (s_axi_rdata[`SSR_S_DONE] !== 1'b1);
        chk(s_axi_rdata, 32'h2);
        wr(`SSR_A_STAT, 32'h2);
    endtask

    function automatic logic [127:0] get(input int k);
        return u_ssr_mem_model.mem[k];
    endfunction

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`SSR_A_FPCW, 32'h0000037F);
        rc(`SSR_A_FEM, 32'h1);
        rc(8'h40, 32'h0, `SSR_RESP_ERR);
        wr(`SSR_A_FEM, 32'h7, 3'h0, `SSR_RESP_ERR);
        wr(`SSR_A_FEM, 32'h5, 3'h1, `SSR_RESP_ERR);
        wr(`SSR_A_FEM, 32'h7);
        rc(`SSR_A_FEM, 32'h7);
        wr(`SSR_A_BASE, 32'h00001000);
        wr(`SSR_A_FPCW, 32'h0000027F);
        wr(`SSR_A_MXCS, 32'h00001F80);
        wr(`SSR_A_WIDX, 32'h44); // media 9
        wr(`SSR_A_WDAT, 32'hA5A50009);
        wr(`SSR_A_WIDX, 32'h24); // media 1
        wr(`SSR_A_WDAT, 32'h00000011);
        u_ssr_mem_model.mem[KB] = PAT;
        u_ssr_mem_model.mem[KB+19] = PAT;
        u_ssr_mem_model.mem[KB+45] = PAT;
        u_ssr_mem_model.mem[KB+32] = 128'h20;
        // x87-only normal save, no pending fault
        wr(`SSR_A_IMLO, 32'h1);
        run(32'h5);
        chk(get(KB+32), 128'h21);
        chk(get(KB) & 16'hFFFF, 16'h027F);
        chk(get(KB) >> 64, PAT >> 64);
        chk(get(KB+19), PAT);
        // all components, legacy mode, stalling memory
        slow <= 1'b1;
        wr(`SSR_A_IMLO, 32'h7);
        run(32'h1);
        chk(get(KB+32), 128'h27);
        chk(get(KB+11) & 32'hFFFFFFFF, 32'h11);
        chk(get(KB+1) >> 64, {`SSR_MXMASK, 32'h00001F80});
        chk(get(KB+19), PAT);
        chk(get(KB+45), PAT);
        // restore with bitmap clear: initial values
        slow <= 1'b0;
        u_ssr_mem_model.mem[KB+32] = 128'h0;
        u_ssr_mem_model.mem[KB+1] = {32'h0, 32'h00001234, 64'h0};
        run(32'h7);
        rc(`SSR_A_FPCW, 32'h0000037F);
        rc(`SSR_A_MXCS, 32'h00001234);
        wr(`SSR_A_WIDX, 32'h84); // upper half 9
        rc(`SSR_A_WDAT, 32'h0);
        wr(`SSR_A_WIDX, 32'h44);
        rc(`SSR_A_WDAT, 32'h0);
        // edited image marks its bitmap bits; x87 left out of the mask
        u_ssr_mem_model.mem[KB] = 128'h0363;
        u_ssr_mem_model.mem[KB+19] = 128'hBEEF;
        u_ssr_mem_model.mem[KB+32] = 128'h7;
        wr(`SSR_A_IMLO, 32'h6);
        run(32'h7);
        rc(`SSR_A_FPCW, 32'h0000037F);
        rc(`SSR_A_WDAT, 32'h0000BEEF);
        stop_test();
    end
endmodule // ssr_engine_test
